// ---- src/rpc_cfg.svh ----
// What this block does
// - Reactive product is voltage times ninety-degree shifted current.
// - The product is low-pass filtered with the active-path power filter.
// - Filtered power is scaled by one plus signed 12-bit gain over 4096.
// - A signed 16-bit offset word is added to cancel crosstalk offsets.
// - 256 offset counts equal one lsb of the waveform output.
// - Shift is minus ninety with integrator on, plus ninety with it off.
// - The result is signed, positive for 0 to +90 degrees, else negative.
// - Reactive samples stream at 25.6/12.8/6.4/3.2 kSPS when selected and ienh bit 5 is set.
// - Sign-change flag bit 4 sets on the transition the polarity picks.
// - An enabled sign-change flag holds the interrupt until cleared.
// - Below the no-load level the flag bit 1 sets, accumulation stops.
// - An enabled no-load flag holds the interrupt until cleared.
// - No-load level 00 is off, 01/10/11 give three thresholds.
`ifndef RPC_CFG_SVH
`define RPC_CFG_SVH
`define RPC_IDX_WAVSRC 8'h0D
`define RPC_IDX_NLCFG  8'h0E
`define RPC_IDX_ACCCFG 8'h0F
`define RPC_IDX_GAIN   8'h1E
`define RPC_IDX_OFS    8'h21
`define RPC_IDX_CHCFG  8'h40
`define RPC_IDX_IENL   8'hD9
`define RPC_IDX_IENH   8'hDB
`define RPC_IDX_ISTL   8'hDC
`define RPC_BIT_NOLOAD 1
`define RPC_BIT_SIGN   4
`define RPC_BIT_WAVEFORM_SAMPLE_ENABLE   5
`define RPC_BIT_POL    5
`define RPC_BIT_INTEG  0
`define RPC_NL_LO      2
`define RPC_NL_HI      3
`define RPC_SRC_LO     2
`define RPC_SRC_HI     4
`define RPC_RATE_LO    0
`define RPC_RATE_HI    1
`define RPC_SRC_VAR    3'h4
`define RPC_GAIN_ONE   13'h1000
`define RPC_GAIN_SH    12
`define RPC_LPF_SH     8
`define RPC_LEAK_SH    6
`define RPC_WAV_LSB    8
`define RPC_NL_THR1    32'h0004EA4B
`define RPC_NL_THR2    32'h00027525
`define RPC_NL_THR3    32'h00013661
`endif

// ---- src/rpc_pkg.sv ----
package rpc_pkg;
  typedef enum logic [2:0] {
    RPC_IDLE, RPC_SHIFT, RPC_MULT, RPC_FILT, RPC_CAL, RPC_OUT
  } rpc_state_e;
  typedef logic signed [31:0] rpc_pwr_t;
endpackage

// ---- src/rpc_lpf.sv ----
`timescale 1ns/10ps
`include "rpc_cfg.svh"
module rpc_lpf #(
  parameter int W  = 32,
  parameter int SH = `RPC_LPF_SH
) (
  input  wire logic                mclk,     // clock
  input  wire logic                reset,    // sync reset
  input  wire logic                in_valid, // new input sample
  input  wire logic signed [W-1:0] x,        // instantaneous product
  output logic signed [W-1:0]      y         // dc estimate
);
  logic signed [W+SH-1:0] acc_q;
  logic signed [W+SH-1:0] acc_d;

  // first-order section; ripple at twice line rate is left for the
  // energy integrator to average away
  always_comb begin
    acc_d = acc_q;
    if (in_valid) begin
      acc_d = acc_q + (W+SH)'(x) - (acc_q >>> SH);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  assign y = acc_q[W+SH-1:SH];
endmodule

// ---- src/rpc_top.sv ----
`timescale 1ns/10ps
`include "rpc_cfg.svh"
module rpc_top (
  input  wire logic               mclk,          // 250 MHz clock
  input  wire logic               reset,         // sync reset, high
  input  wire logic               sample_valid,  // one dsp sample strobe
  input  wire logic signed [23:0] v_sample,      // voltage channel
  input  wire logic signed [23:0] i_sample,      // current channel
  input  wire logic [9:0]         wb_adr_i,      // byte address
  input  wire logic [31:0]        wb_dat_i,      // write data
  input  wire logic [3:0]         wb_sel_i,      // byte enables
  input  wire logic               wb_we_i,       // write
  input  wire logic               wb_cyc_i,      // cycle
  input  wire logic               wb_stb_i,      // strobe
  output logic [31:0]             wb_dat_o,      // read data
  output logic                    wb_ack_o,      // acknowledge
  output logic signed [23:0]      wave_data,     // reactive waveform
  output logic                    wave_valid,    // waveform sample pulse
  output logic                    var_inhibit,   // stop var accumulation
  output logic                    irq_pending    // metering interrupt
);
  rpc_pkg::rpc_state_e st_q;
  rpc_pkg::rpc_state_e st_d;

  logic [11:0] gain_q, gain_d;
  logic [15:0] ofs_q, ofs_d;
  logic [7:0]  wavsrc_q, wavsrc_d, nlcfg_q, nlcfg_d, acccfg_q, acccfg_d;
  logic [7:0]  chcfg_q, chcfg_d, ienl_q, ienl_d, ienh_q, ienh_d;
  logic [7:0]  istl_q, istl_d;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;

  logic signed [31:0] integ_q, integ_d;
  logic signed [23:0] shift_q, shift_d;
  logic signed [31:0] prod_q, prod_d;
  logic signed [31:0] lpf_y;
  rpc_pkg::rpc_pwr_t  gpwr_q, gpwr_d;
  rpc_pkg::rpc_pwr_t  cal_q, cal_d;
  logic signed [23:0] wave_q, wave_d;
  logic        wval_q, wval_d;
  logic        neg_q, neg_d, seen_q, seen_d, inh_q, inh_d;
  logic [2:0]  dec_q, dec_d;

  logic               wr_en, rd_en, sgn_ev, nl_ev;
  logic [7:0]         idx;
  logic signed [47:0] vi;
  logic signed [44:0] gprod;
  logic signed [31:0] cal_n, cal_mag, thr;
  logic [1:0]         nl_lvl;

  function automatic logic [7:0] wr_byte(input logic [7:0] old,
                                         input logic [7:0] nw,
                                         input logic       en);
    wr_byte = en ? nw : old;
  endfunction

  function automatic logic signed [31:0] mag(input logic signed [31:0] a);
    mag = a[31] ? -a : a;
  endfunction

  // ---------------- register bus ----------------
  assign idx   = wb_adr_i[9:2];
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
  assign rd_en = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;

  always_comb begin
    gain_d   = gain_q;
    ofs_d    = ofs_q;
    wavsrc_d = wavsrc_q;
    nlcfg_d  = nlcfg_q;
    acccfg_d = acccfg_q;
    chcfg_d  = chcfg_q;
    ienl_d   = ienl_q;
    ienh_d   = ienh_q;
    ack_d    = wb_cyc_i & wb_stb_i & ~ack_q;
    rdat_d   = '0;
    if (wr_en) begin
      unique case (idx)
        `RPC_IDX_GAIN: begin
          gain_d[7:0]  = wr_byte(gain_q[7:0], wb_dat_i[7:0], wb_sel_i[0]);
          gain_d[11:8] = wb_sel_i[1] ? wb_dat_i[11:8] : gain_q[11:8];
        end
        `RPC_IDX_OFS: begin
          ofs_d[7:0]  = wr_byte(ofs_q[7:0], wb_dat_i[7:0], wb_sel_i[0]);
          ofs_d[15:8] = wr_byte(ofs_q[15:8], wb_dat_i[15:8], wb_sel_i[1]);
        end
        `RPC_IDX_WAVSRC:
          wavsrc_d = wr_byte(wavsrc_q, wb_dat_i[7:0], wb_sel_i[0]);
        `RPC_IDX_NLCFG:
          nlcfg_d = wr_byte(nlcfg_q, wb_dat_i[7:0], wb_sel_i[0]);
        `RPC_IDX_ACCCFG:
          acccfg_d = wr_byte(acccfg_q, wb_dat_i[7:0], wb_sel_i[0]);
        `RPC_IDX_CHCFG:
          chcfg_d = wr_byte(chcfg_q, wb_dat_i[7:0], wb_sel_i[0]);
        `RPC_IDX_IENL:
          ienl_d = wr_byte(ienl_q, wb_dat_i[7:0], wb_sel_i[0]);
        `RPC_IDX_IENH:
          ienh_d = wr_byte(ienh_q, wb_dat_i[7:0], wb_sel_i[0]);
        default: ;
      endcase
    end
    if (rd_en) begin
      unique case (idx)
        `RPC_IDX_GAIN:   rdat_d = {20'h00000, gain_q};
        `RPC_IDX_OFS:    rdat_d = {16'h0000, ofs_q};
        `RPC_IDX_WAVSRC: rdat_d = {24'h000000, wavsrc_q};
        `RPC_IDX_NLCFG:  rdat_d = {24'h000000, nlcfg_q};
        `RPC_IDX_ACCCFG: rdat_d = {24'h000000, acccfg_q};
        `RPC_IDX_CHCFG:  rdat_d = {24'h000000, chcfg_q};
        `RPC_IDX_IENL:   rdat_d = {24'h000000, ienl_q};
        `RPC_IDX_IENH:   rdat_d = {24'h000000, ienh_q};
        `RPC_IDX_ISTL:   rdat_d = {24'h000000, istl_q};
        default:         rdat_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      gain_q   <= '0;
      ofs_q    <= '0;
      wavsrc_q <= '0;
      nlcfg_q  <= '0;
      acccfg_q <= '0;
      chcfg_q  <= '0;
      ienl_q   <= '0;
      ienh_q   <= '0;
      ack_q    <= 1'b0;
      rdat_q   <= '0;
    end else begin
      gain_q   <= gain_d;
      ofs_q    <= ofs_d;
      wavsrc_q <= wavsrc_d;
      nlcfg_q  <= nlcfg_d;
      acccfg_q <= acccfg_d;
      chcfg_q  <= chcfg_d;
      ienl_q   <= ienl_d;
      ienh_q   <= ienh_d;
      ack_q    <= ack_d;
      rdat_q   <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ---------------- signal path ----------------
  assign vi     = v_sample * shift_q;
  assign gprod  = lpf_y * $signed({1'b0, `RPC_GAIN_ONE})
                + lpf_y * $signed(gain_q);
  assign cal_n  = gpwr_q + 32'(signed'(ofs_q));
  assign cal_mag = mag(cal_n);
  assign nl_lvl = nlcfg_q[`RPC_NL_HI:`RPC_NL_LO];

  always_comb begin
    unique case (nl_lvl)
      2'h1:    thr = `RPC_NL_THR1;
      2'h2:    thr = `RPC_NL_THR2;
      2'h3:    thr = `RPC_NL_THR3;
      default: thr = '0;
    endcase
  end

  rpc_lpf #(.W(32), .SH(`RPC_LPF_SH)) u_lpf (
    .mclk     (mclk),
    .reset    (reset),
    .in_valid (st_q == rpc_pkg::RPC_FILT),
    .x        (prod_q),
    .y        (lpf_y)
  );

  // sign test is only meaningful once one sample has set neg_q
  assign sgn_ev = (st_q == rpc_pkg::RPC_OUT) && seen_q &&
                  (acccfg_q[`RPC_BIT_POL] ? (neg_q && !cal_n[31])
                                          : (!neg_q && cal_n[31]));
  assign nl_ev  = (st_q == rpc_pkg::RPC_OUT) && (nl_lvl != 2'h0) &&
                  (cal_mag < thr);

  always_comb begin
    st_d    = st_q;
    integ_d = integ_q;
    shift_d = shift_q;
    prod_d  = prod_q;
    gpwr_d  = gpwr_q;
    cal_d   = cal_q;
    wave_d  = wave_q;
    wval_d  = 1'b0;
    neg_d   = neg_q;
    seen_d  = seen_q;
    inh_d   = inh_q;
    dec_d   = dec_q;
    istl_d  = istl_q;
    unique case (st_q)
      rpc_pkg::RPC_IDLE: if (sample_valid) st_d = rpc_pkg::RPC_SHIFT;
      rpc_pkg::RPC_SHIFT: begin
        // leaky integrator lags ~90 degrees near line rate, leak stops drift
        integ_d = integ_q + 32'(i_sample) - (integ_q >>> `RPC_LEAK_SH);
        shift_d = chcfg_q[`RPC_BIT_INTEG] ? integ_d[31:8]
                                          : -integ_d[31:8];
        st_d    = rpc_pkg::RPC_MULT;
      end
      rpc_pkg::RPC_MULT: begin
        prod_d = vi[46:15];
        st_d   = rpc_pkg::RPC_FILT;
      end
      rpc_pkg::RPC_FILT: st_d = rpc_pkg::RPC_CAL;
      rpc_pkg::RPC_CAL: begin
        gpwr_d = gprod[43:12];
        st_d   = rpc_pkg::RPC_OUT;
      end
      rpc_pkg::RPC_OUT: begin
        cal_d  = cal_n;
        neg_d  = cal_n[31];
        seen_d = 1'b1;
        inh_d  = nl_ev;
        dec_d  = dec_q + 3'h1;
        if (ienh_q[`RPC_BIT_WAVEFORM_SAMPLE_ENABLE] &&
            wavsrc_q[`RPC_SRC_HI:`RPC_SRC_LO] == `RPC_SRC_VAR &&
            ((dec_q & ((3'h1 << wavsrc_q[`RPC_RATE_HI:`RPC_RATE_LO])
                      - 3'h1)) == 3'h0)) begin
          wave_d = cal_n[31:`RPC_WAV_LSB];
          wval_d = 1'b1;
        end
        st_d = rpc_pkg::RPC_IDLE;
      end
      default: st_d = rpc_pkg::RPC_IDLE;
    endcase
    // write-one-to-clear, a same-cycle event wins
    if (wr_en && idx == `RPC_IDX_ISTL && wb_sel_i[0]) begin
      istl_d = istl_q & ~wb_dat_i[7:0];
    end
    if (sgn_ev) istl_d[`RPC_BIT_SIGN] = 1'b1;
    if (nl_ev)  istl_d[`RPC_BIT_NOLOAD] = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q    <= rpc_pkg::RPC_IDLE;
      integ_q <= '0;
      shift_q <= '0;
      prod_q  <= '0;
      gpwr_q  <= '0;
      cal_q   <= '0;
      wave_q  <= '0;
      wval_q  <= 1'b0;
      neg_q   <= 1'b0;
      seen_q  <= 1'b0;
      inh_q   <= 1'b0;
      dec_q   <= '0;
      istl_q  <= '0;
    end else begin
      st_q    <= st_d;
      integ_q <= integ_d;
      shift_q <= shift_d;
      prod_q  <= prod_d;
      gpwr_q  <= gpwr_d;
      cal_q   <= cal_d;
      wave_q  <= wave_d;
      wval_q  <= wval_d;
      neg_q   <= neg_d;
      seen_q  <= seen_d;
      inh_q   <= inh_d;
      dec_q   <= dec_d;
      istl_q  <= istl_d;
    end
  end

  assign wave_data   = wave_q;
  assign wave_valid  = wval_q;
  assign var_inhibit = inh_q;
  assign irq_pending = |(istl_q & ienl_q &
                         8'((1 << `RPC_BIT_SIGN) | (1 << `RPC_BIT_NOLOAD)));

  // ---------------- checks ----------------
  sequence s_start;
    st_q == rpc_pkg::RPC_IDLE && sample_valid;
  endsequence
  sequence s_done;
    st_q == rpc_pkg::RPC_OUT ##1 st_q == rpc_pkg::RPC_IDLE;
  endsequence
  property p_pipe;
    @(posedge mclk) disable iff (reset) s_start |=> ##4 s_done;
  endproperty
  a_pipe: assert property (p_pipe)
    else $error("sample pipeline did not finish in five cycles");
  property p_ack;
    @(posedge mclk) disable iff (reset)
      (wb_cyc_i && wb_stb_i && !ack_q) |=> ack_q ##1 !ack_q;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus ack not a single cycle after request");
  property p_sign;
    @(posedge mclk) disable iff (reset)
      (st_q == rpc_pkg::RPC_OUT && seen_q && !acccfg_q[`RPC_BIT_POL] &&
       !neg_q && cal_n[31]) |=> istl_q[`RPC_BIT_SIGN];
  endproperty
  a_sign: assert property (p_sign)
    else $error("positive to negative change not flagged");
  property p_sign_pol;
    @(posedge mclk) disable iff (reset)
      (!istl_q[`RPC_BIT_SIGN] && acccfg_q[`RPC_BIT_POL] &&
       $rose(istl_q[`RPC_BIT_SIGN]) == 1'b0 ##1 istl_q[`RPC_BIT_SIGN])
      |-> $past(neg_q) && !neg_q;
  endproperty
  a_sign_pol: assert property (p_sign_pol)
    else $error("sign flag set without negative to positive change");
  property p_hold;
    @(posedge mclk) disable iff (reset)
      (istl_q[`RPC_BIT_SIGN] && ienl_q[`RPC_BIT_SIGN] &&
       !(wr_en && idx == `RPC_IDX_ISTL)) |=> irq_pending;
  endproperty
  a_hold: assert property (p_hold)
    else $error("interrupt dropped while sign flag pending");
  property p_nl_irq;
    @(posedge mclk) disable iff (reset)
      (nl_ev && ienl_q[`RPC_BIT_NOLOAD] && !wr_en) |=> irq_pending;
  endproperty
  a_nl_irq: assert property (p_nl_irq)
    else $error("no-load flag enabled but no interrupt");
  property p_nl;
    @(posedge mclk) disable iff (reset)
      (st_q == rpc_pkg::RPC_OUT && nl_lvl == 2'h1 &&
       cal_mag < `RPC_NL_THR1) |=> var_inhibit && istl_q[`RPC_BIT_NOLOAD];
  endproperty
  a_nl: assert property (p_nl)
    else $error("no-load not detected below threshold");
  property p_nl_off;
    @(posedge mclk) disable iff (reset)
      (st_q == rpc_pkg::RPC_OUT && nl_lvl == 2'h0) |=> !var_inhibit;
  endproperty
  a_nl_off: assert property (p_nl_off)
    else $error("no-load active while disabled");
  property p_wave;
    @(posedge mclk) disable iff (reset)
      wave_valid |-> $past(st_q) == rpc_pkg::RPC_OUT &&
        ienh_q[`RPC_BIT_WAVEFORM_SAMPLE_ENABLE] && wave_data == cal_q[31:`RPC_WAV_LSB];
  endproperty
  a_wave: assert property (p_wave)
    else $error("waveform sample without enable or wrong value");
endmodule

// ---- dv/rpc_core_model.sv ----
`timescale 1ns/10ps
module rpc_core_model (
  input  wire logic        mclk,     // clock
  input  wire logic [31:0] wb_dat_o, // read data
  input  wire logic        wb_ack_o, // acknowledge
  output logic [9:0]       wb_adr_i, // byte address
  output logic [31:0]      wb_dat_i, // write data
  output logic [3:0]       wb_sel_i, // byte enables
  output logic             wb_we_i,  // write
  output logic             wb_cyc_i, // cycle
  output logic             wb_stb_i, // strobe
  output logic             hung      // ack never came
);
  initial begin
    {wb_adr_i, wb_dat_i, wb_sel_i, wb_we_i, wb_cyc_i, wb_stb_i} = '0;
    hung = 1'b0;
  end
  // one classic cycle; request held until ack is sampled high
  task automatic xfer(input logic we, input logic [7:0] idx,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    {wb_adr_i, wb_dat_i, wb_sel_i} <= {idx, 2'b00, d, 4'h3};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 64);
    hung = hung | (n >= 64);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    // released data must not look like a valid word
    wb_dat_i <= ~d;
    @(posedge mclk);
  endtask
endmodule

// ---- dv/rpc_top_bench.sv ----
`timescale 1ns/10ps
`include "rpc_cfg.svh"
module rpc_top_bench;
  logic               mclk, reset, sample_valid, wb_ack_o, wb_we_i;
  logic               wb_cyc_i, wb_stb_i, wave_valid, var_inhibit;
  logic               irq_pending;
  logic signed [23:0] v_sample, i_sample, wave_data, last_w, w0;
  logic [9:0]         wb_adr_i;
  logic [31:0]        wb_dat_i, wb_dat_o, rd;
  logic [3:0]         wb_sel_i;
  logic signed [31:0] e;
  int                 n_fail, n_checks, got;
  logic [15:0]        ofs_in [6] = '{16'h0100, 16'hFF00, 16'h7FFF,
                                     16'h8000, 16'h00FF, 16'hFFFF};
  logic [23:0]        ofs_out [6] = '{24'h000001, 24'hFFFFFF, 24'h00007F,
                                      24'hFFFF80, 24'h000000, 24'hFFFFFF};
  logic [7:0]         rcfg [6][3] = '{'{8'h20, 8'h10, 8'h10},
    '{8'h20, 8'h11, 8'h08}, '{8'h20, 8'h12, 8'h04}, '{8'h20, 8'h13, 8'h02},
    '{8'h00, 8'h10, 8'h00}, '{8'h20, 8'h0C, 8'h00}};
  logic [11:0]        gains [3] = '{12'h7FF, 12'h800, 12'h400};

  rpc_top u_dut (.mclk(mclk), .reset(reset), .sample_valid(sample_valid),
    .v_sample(v_sample), .i_sample(i_sample), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wave_data(wave_data), .wave_valid(wave_valid),
    .var_inhibit(var_inhibit), .irq_pending(irq_pending));
  rpc_core_model u_core (.mclk(mclk), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .hung());

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic bad(input logic [31:0] g, input logic [31:0] x);
    n_fail++;
    $display("unexpected at %0t: got %h want %h", $time, g, x);
  endtask
  task automatic chk_w(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) bad(g, x);
  endtask
  task automatic chk_b(input logic g, input logic x);
    n_checks++;
    if (g !== x) bad(32'(g), 32'(x));
  endtask
  // filter ripple and truncation allow a few lsb of slack
  task automatic chk_near(input logic signed [31:0] g,
                          input logic signed [31:0] x);
    n_checks++;
    if ($isunknown(g) || g - x > 4 || x - g > 4) bad(g, x);
  endtask
  task automatic xf(input logic we, input logic [7:0] idx,
                    input logic [31:0] d);
    u_core.xfer(we, idx, d, rd);
    if (u_core.hung) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xf(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] x);
    xf(1'b0, idx, 32'h0);
    chk_w(rd, x);
  endtask
  // outputs land five edges after the taking edge; seven covers it
  task automatic smp(input logic signed [23:0] v, input logic signed [23:0] i);
    @(posedge mclk);
    sample_valid <= 1'b1;
    {v_sample, i_sample} <= {v, i};
    @(posedge mclk);
    sample_valid <= 1'b0;
    got = 0;
    repeat (7) begin
      @(posedge mclk);
      if (wave_valid === 1'b1) begin
        got++;
        last_w = wave_data;
      end
    end
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end

  initial begin
    {reset, sample_valid, v_sample, i_sample} = {1'b1, 49'h0};
    {n_fail, n_checks} = 0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk_b(irq_pending, 1'b0);
    rdc(`RPC_IDX_GAIN, 32'h0);
    wr(`RPC_IDX_GAIN, 32'hFFFFFFFF);
    rdc(`RPC_IDX_GAIN, 32'h00000FFF);
    wr(`RPC_IDX_OFS, 32'hFFFFFFFF);
    rdc(`RPC_IDX_OFS, 32'h0000FFFF);
    wr(8'h30, 32'hFFFFFFFF);
    rdc(8'h30, 32'h0);
    wr(`RPC_IDX_GAIN, 32'h0);
    wr(`RPC_IDX_IENH, 32'h20);
    wr(`RPC_IDX_WAVSRC, 32'h10);
    for (int r = 0; r < 6; r++) begin
      wr(`RPC_IDX_OFS, {16'h0, ofs_in[r]});
      smp(24'h0, 24'h0);
      chk_w(32'(got), 32'h1);
      chk_w({8'h0, last_w}, {8'h0, ofs_out[r]});
    end
    for (int p = 0; p < 2; p++) begin
      wr(`RPC_IDX_ACCCFG, 32'(p) << 5);
      wr(`RPC_IDX_IENL, 32'h10);
      wr(`RPC_IDX_OFS, 32'h0100);
      smp(24'h0, 24'h0);
      wr(`RPC_IDX_ISTL, 32'hFF);
      wr(`RPC_IDX_OFS, 32'hFF00);
      smp(24'h0, 24'h0);
      rdc(`RPC_IDX_ISTL, p == 0 ? 32'h10 : 32'h0);
      chk_b(irq_pending, p == 0);
      wr(`RPC_IDX_OFS, 32'h0100);
      smp(24'h0, 24'h0);
      rdc(`RPC_IDX_ISTL, 32'h10);
      chk_b(irq_pending, 1'b1);
      wr(`RPC_IDX_ISTL, 32'h10);
      chk_b(irq_pending, 1'b0);
    end
    wr(`RPC_IDX_IENL, 32'h02);
    for (int l = 0; l < 4; l++) begin
      wr(`RPC_IDX_NLCFG, 32'(l) << 2);
      wr(`RPC_IDX_ISTL, 32'hFF);
      smp(24'h0, 24'h0);
      rdc(`RPC_IDX_ISTL, l != 0 ? 32'h02 : 32'h0);
      chk_b(var_inhibit, l != 0);
      chk_b(irq_pending, l != 0);
    end
    wr(`RPC_IDX_IENL, 32'h0);
    chk_b(irq_pending, 1'b0);
    rdc(`RPC_IDX_ISTL, 32'h02);
    for (int r = 0; r < 6; r++) begin
      wr(`RPC_IDX_IENH, {24'h0, rcfg[r][0]});
      wr(`RPC_IDX_WAVSRC, {24'h0, rcfg[r][1]});
      e = 0;
      repeat (16) begin
        smp(24'h0, 24'h0);
        e = e + got;
      end
      chk_w(e, {24'h0, rcfg[r][2]});
    end
    wr(`RPC_IDX_WAVSRC, 32'h10);
    wr(`RPC_IDX_OFS, 32'h0);
    wr(`RPC_IDX_CHCFG, 32'h1);
    wr(`RPC_IDX_NLCFG, 32'h0C);
    // long run so the phase shifter and the power filter settle
    repeat (1200) smp(24'h100000, 24'h010000);
    chk_b(var_inhibit, 1'b0);
    w0 = last_w;
    chk_b(w0 > 64 || w0 < -64, 1'b1);
    for (int g = 0; g < 3; g++) begin
      wr(`RPC_IDX_GAIN, {20'h0, gains[g]});
      smp(24'h100000, 24'h010000);
      e = (32'(w0) * (32'sd4096 + 32'($signed(gains[g])))) >>> 12;
      chk_near(32'(last_w), e);
    end
    // integrator off negates the shifted current, so the product flips
    wr(`RPC_IDX_GAIN, 32'h0);
    wr(`RPC_IDX_CHCFG, 32'h0);
    repeat (1200) smp(24'h100000, 24'h010000);
    chk_b(last_w < -64, 1'b1);
    // mid-run reset must clear flags, words and the waveform
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk_w({8'h0, wave_data}, 32'h0);
    chk_b(var_inhibit | wave_valid | irq_pending, 1'b0);
    rdc(`RPC_IDX_ISTL, 32'h0);
    rdc(`RPC_IDX_GAIN, 32'h0);
    give_verdict();
  end
endmodule
